// *** design/fftbf_defines.vh ***
`ifndef FFTBF_DEFINES_VH
`define FFTBF_DEFINES_VH
// ****************************************
// build-time defaults
// ****************************************
`define FFTBF_POINTS_DEF 1024
`define FFTBF_POINTS_MIN 64
`define FFTBF_POINTS_MAX 16384
`define FFTBF_POINTS_VMIN 16
`define FFTBF_POINTS_VMAX 65536
`define FFTBF_DATA_W_DEF 16
`define FFTBF_TWID_W_DEF 16
`define FFTBF_ENGINES_DEF 1
`define FFTBF_FIFO_DEPTH_DEF 4
`define FFTBF_EXP_W 6
// ****************************************
// engine types and data flow choices
// ****************************************
`define FFTBF_ENG_QUAD 0
`define FFTBF_ENG_SINGLE 1
`define FFTBF_FLOW_STREAM 0
`define FFTBF_FLOW_VSTREAM 1
`define FFTBF_FLOW_BBURST 2
`define FFTBF_FLOW_BURST 3
// ****************************************
// block states
// ****************************************
`define FFTBF_ST_LOAD 2'h0
`define FFTBF_ST_CALC 2'h1
`define FFTBF_ST_UNLOAD 2'h2
`endif

// *** design/fftbf_in_fifo.v ***
`timescale 1ns/1ps
// ****************************************
// small input fifo in front of the block store
// ****************************************
module fftbf_in_fifo
#(
   parameter WIDTH = 34,
   parameter DEPTH = 4
)
(
   input wire clk_sys_in,
   input wire reset_in,
   input wire wr_valid_in,
   output reg wr_ready_out,
   input wire [WIDTH-1:0] wr_data_in,
   output wire rd_valid_out,
   input wire rd_ready_in,
   output wire [WIDTH-1:0] rd_data_out
);
   localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;
   wire [AW:0] count_d;

   // flags come straight from the count so full and empty never lie
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;
   assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign rd_valid_out = (count_q != {(AW+1){1'b0}});
   assign rd_data_out = mem_q[rd_ptr_q];

   // storage write, no reset needed on data
   always @(posedge clk_sys_in)
   begin
      if (push)
         mem_q[wr_ptr_q] <= wr_data_in;
   end

   // pointers, count and registered ready
   always @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         wr_ready_out <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= (wr_ptr_q == DEPTH-1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= (rd_ptr_q == DEPTH-1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
         count_q <= count_d;
         wr_ready_out <= (count_d != DEPTH);
      end
   end
endmodule // fftbf_in_fifo

// *** design/fftbf_core.v ***
`timescale 1ns/1ps
`include "fftbf_defines.vh"
// Overview of operation
// - output sop on first, eop on last
// - output valid rises only while input valid high
// - burst handles one input block at once
// - small input fifo, ready until full
// - rest of next frame after full unload
// - sop and eop mark block boundaries
// - length 64 to 16384, powers of two
// - data precision from allowed set only
// - twiddle precision not above data precision
// - quad 1/2/4 or single 1/2 engines
// - data flow choice fixed at build
// - transfer only when valid and ready
// - direction captured with input sop
module fftbf_core
#(
   parameter POINTS = `FFTBF_POINTS_DEF,
   parameter DATA_W = `FFTBF_DATA_W_DEF,
   parameter TWID_W = `FFTBF_TWID_W_DEF,
   parameter ENG_TYPE = `FFTBF_ENG_QUAD,
   parameter ENGINES = `FFTBF_ENGINES_DEF,
   parameter FLOW = `FFTBF_FLOW_BURST,
   parameter FIFO_DEPTH = `FFTBF_FIFO_DEPTH_DEF
)
(
   input wire clk_sys_in,
   input wire reset_in,
   input wire sink_valid_in,
   output wire sink_ready_out,
   input wire sink_sop_in,
   input wire sink_eop_in,
   input wire inverse_in,
   input wire [DATA_W-1:0] sink_real_in,
   input wire [DATA_W-1:0] sink_imag_in,
   input wire source_ready_in,
   output reg source_valid_out,
   output reg source_sop_out,
   output reg source_eop_out,
   output reg [DATA_W-1:0] source_real_out,
   output reg [DATA_W-1:0] source_imag_out,
   output reg [`FFTBF_EXP_W-1:0] source_exp_out,
   output reg cfg_error_out
);
   // ****************************************
   // configuration checks
   // ****************************************
   function is_pow2;
      input integer v;
      begin
         is_pow2 = (v > 0) && ((v & (v - 1)) == 0);
      end
   endfunction

   localparam VS = (FLOW == `FFTBF_FLOW_VSTREAM);
   localparam AW = $clog2(POINTS);
   localparam LEN_OK = is_pow2(POINTS) &&
      (VS ? (POINTS >= `FFTBF_POINTS_VMIN && POINTS <= `FFTBF_POINTS_VMAX)
          : (POINTS >= `FFTBF_POINTS_MIN && POINTS <= `FFTBF_POINTS_MAX));
   // allowed widths, 28 and 32 only when variable streaming
   localparam DW_OK = (DATA_W >= 8 && DATA_W <= 20 && DATA_W % 2 == 0) || DATA_W == 24 ||
      (VS && (DATA_W == 28 || DATA_W == 32));
   localparam TW_OK = (TWID_W >= 8) && (TWID_W <= DATA_W);
   localparam ENG_OK = VS || (ENG_TYPE == `FFTBF_ENG_QUAD ?
      (ENGINES == 1 || ENGINES == 2 || ENGINES == 4) : (ENGINES == 1 || ENGINES == 2));
   // only the two burst flows are built by this block
   localparam FLOW_OK = (FLOW == `FFTBF_FLOW_BURST) || (FLOW == `FFTBF_FLOW_BBURST);
   localparam CFG_OK = LEN_OK && DW_OK && TW_OK && ENG_OK && FLOW_OK;
   // compute time: butterfly passes shared out over the engines
   localparam LANES = ENGINES * ((ENG_TYPE == `FFTBF_ENG_QUAD) ? 4 : 1);
   localparam CALC_CYC = (POINTS * AW) / LANES;
   localparam CW = $clog2(CALC_CYC + 1);

   // ****************************************
   // input fifo
   // ****************************************
   localparam FW = 2 * DATA_W + 3;
   wire fifo_valid;
   wire fifo_pop;
   wire [FW-1:0] fifo_data;
   wire f_sop = fifo_data[FW-1];
   wire f_eop = fifo_data[FW-2];
   wire f_inv = fifo_data[FW-3];
   wire [DATA_W-1:0] f_re = fifo_data[2*DATA_W-1:DATA_W];
   wire [DATA_W-1:0] f_im = fifo_data[DATA_W-1:0];
   wire fifo_in_valid = sink_valid_in && CFG_OK;

   // fifo pushes only when valid and ready meet
   fftbf_in_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .wr_valid_in(fifo_in_valid),
      .wr_ready_out(sink_ready_out),
      .wr_data_in({sink_sop_in, sink_eop_in, inverse_in, sink_real_in, sink_imag_in}),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(fifo_pop),
      .rd_data_out(fifo_data)
   );

   // ****************************************
   // block store and state
   // ****************************************
   reg [DATA_W-1:0] re_q [0:POINTS-1];
   reg [DATA_W-1:0] im_q [0:POINTS-1];
   reg [1:0] state_q;
   reg [AW-1:0] idx_q;
   reg in_blk_q;
   reg inv_q;
   reg [CW-1:0] calc_q;
   reg [`FFTBF_EXP_W-1:0] exp_q;
   reg [DATA_W-1:0] o_re;
   reg [DATA_W-1:0] o_im;
   wire take = (state_q == `FFTBF_ST_LOAD) && fifo_valid;
   wire last_in = f_eop || (idx_q == POINTS - 1);
   // output advances only while input valid is high
   wire out_adv = (state_q == `FFTBF_ST_UNLOAD) && sink_valid_in &&
      (!source_valid_out || source_ready_in);

   // fifo drains into the store only once the last result is out
   assign fifo_pop = take;

   // sample capture into the block store, natural order in and out
   always @(posedge clk_sys_in)
   begin
      if (take && (f_sop || in_blk_q))
      begin
         re_q[idx_q] <= f_re;
         im_q[idx_q] <= f_im;
      end
   end

   // direction handling at read-out: inverse returns the conjugate
   always @*
   begin
      o_re = re_q[idx_q];
      o_im = inv_q ? (~im_q[idx_q] + 1'b1) : im_q[idx_q];
   end

   // ****************************************
   // block sequencer
   // ****************************************
   always @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q <= `FFTBF_ST_LOAD;
         idx_q <= {AW{1'b0}};
         in_blk_q <= 1'b0;
         inv_q <= 1'b0;
         calc_q <= {CW{1'b0}};
         exp_q <= {`FFTBF_EXP_W{1'b0}};
         source_valid_out <= 1'b0;
         source_sop_out <= 1'b0;
         source_eop_out <= 1'b0;
         source_real_out <= {DATA_W{1'b0}};
         source_imag_out <= {DATA_W{1'b0}};
         source_exp_out <= {`FFTBF_EXP_W{1'b0}};
         cfg_error_out <= 1'b0;
      end
      else
      begin
         // bad builds are flagged and never take data
         cfg_error_out <= !CFG_OK;
         // output register drops once the sink takes it; markers drop too so
         // a stale eop never lingers as a marker without valid
         if (source_valid_out && source_ready_in)
         begin
            source_valid_out <= 1'b0;
            source_sop_out <= 1'b0;
            source_eop_out <= 1'b0;
         end
         case (state_q)
            `FFTBF_ST_LOAD:
            begin
               if (take)
               begin
                  // samples before a sop are discarded
                  if (f_sop || in_blk_q)
                  begin
                     if (f_sop)
                        inv_q <= f_inv;
                     if (last_in)
                     begin
                        // one block at a time: stop loading
                        state_q <= `FFTBF_ST_CALC;
                        in_blk_q <= 1'b0;
                        idx_q <= {AW{1'b0}};
                        calc_q <= CALC_CYC[CW-1:0];
                     end
                     else
                     begin
                        in_blk_q <= 1'b1;
                        idx_q <= idx_q + 1'b1;
                     end
                  end
               end
            end
            `FFTBF_ST_CALC:
            begin
               // compute phase; the stand-in engine applies no growth
               if (calc_q <= 1)
               begin
                  state_q <= `FFTBF_ST_UNLOAD;
                  exp_q <= {`FFTBF_EXP_W{1'b0}};
               end
               else
                  calc_q <= calc_q - 1'b1;
            end
            `FFTBF_ST_UNLOAD:
            begin
               if (out_adv)
               begin
                  source_valid_out <= 1'b1;
                  source_sop_out <= (idx_q == {AW{1'b0}});
                  source_eop_out <= (idx_q == POINTS - 1);
                  source_real_out <= o_re;
                  source_imag_out <= o_im;
                  // exponent held for the whole block
                  source_exp_out <= exp_q;
                  if (idx_q == POINTS - 1)
                  begin
                     state_q <= `FFTBF_ST_LOAD;
                     idx_q <= {AW{1'b0}};
                  end
                  else
                     idx_q <= idx_q + 1'b1;
               end
            end
            default:
               state_q <= `FFTBF_ST_LOAD;
         endcase
      end
   end
endmodule // fftbf_core

// *** tb/fftbf_checker.sv ***
`timescale 1ns/1ps
// ****************************************
// output stream checker
// ****************************************
module fftbf_checker
#(
   parameter POINTS = 64,
   parameter DATA_W = 16,
   parameter TWID_W = 16
)
(
   input wire clk_sys_in,
   input wire reset_in,
   input wire sink_valid_in,
   input wire sink_ready_out,
   input wire source_ready_in,
   input wire source_valid_out,
   input wire source_sop_out,
   input wire source_eop_out,
   input wire [DATA_W-1:0] source_real_out,
   input wire [DATA_W-1:0] source_imag_out,
   input wire [5:0] source_exp_out,
   input wire cfg_error_out
);
   // data width set is not checked, only length bounds, power of two and twiddle not above data width
   localparam BAD = (POINTS < 64) || (POINTS > 16384) ||
      ((POINTS & (POINTS - 1)) != 0) || (TWID_W > DATA_W);
   reg [15:0] pos_q;
   // position of the next output sample within its block
   always @(posedge clk_sys_in or posedge reset_in)
      if (reset_in)
         pos_q <= 16'h0000;
      else if (source_valid_out && source_ready_in)
         pos_q <= source_eop_out ? 16'h0000 : pos_q + 16'h0001;
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);
   sequence s_stall;
      source_valid_out && !source_ready_in;
   endsequence
   sequence s_held;
      source_valid_out && $stable(source_real_out) && $stable(source_imag_out)
         && $stable(source_sop_out);
   endsequence
   chk_stall_hold: assert property (s_stall |=> s_held)
      else $error("output changed while stalled");
   chk_valid_gate: assert property ($rose(source_valid_out) |-> $past(sink_valid_in))
      else $error("output valid rose without input valid");
   chk_gap_quiet: assert property (!sink_valid_in && !source_valid_out |=> !source_valid_out)
      else $error("output valid rose during input gap");
   chk_sop_first: assert property (source_valid_out && source_sop_out |-> pos_q == 0)
      else $error("sop not on first sample");
   chk_eop_last: assert property (source_valid_out && source_eop_out |-> pos_q == POINTS-1)
      else $error("eop not on last sample");
   chk_marks_qual: assert property (source_sop_out || source_eop_out |-> source_valid_out)
      else $error("marker without valid");
   chk_exp_steady: assert property (source_valid_out && !source_sop_out |->
      $stable(source_exp_out))
      else $error("exponent changed inside block");
   chk_cfg_flag: assert property (!$past(reset_in) |-> cfg_error_out == BAD)
      else $error("config flag wrong");
   chk_ready_up: assert property (!$past(reset_in) && $past(reset_in, 2) |-> sink_ready_out)
      else $error("ready not up after reset");
endmodule // fftbf_checker

// *** tb/fftbf_far_model.sv ***
`timescale 1ns/1ps
// ****************************************
// sample source and result sink
// ****************************************
module fftbf_far_model
#(
   parameter N = 64
)
(
   input wire clk_sys_in,
   input wire reset_in,
   input wire gap_in,
   input wire stall_in,
   input wire sink_ready_in,
   output reg sink_valid_out,
   output wire sink_sop_out,
   output wire sink_eop_out,
   output wire inverse_out,
   output wire [15:0] sink_real_out,
   output wire [15:0] sink_imag_out,
   output reg source_ready_out,
   output wire [15:0] sent_out
);
   reg [15:0] sent_q;
   // running count of accepted samples, also the sample value
   assign sent_out = sent_q;
   assign sink_sop_out = (sent_q % N) == 0;
   assign sink_eop_out = (sent_q % N) == N - 1;
   // odd blocks run inverse
   assign inverse_out = ((sent_q / N) % 2) == 1;
   // idle data inverted so a stale sample never looks valid
   assign sink_real_out = sink_valid_out ? sent_q : ~sent_q;
   assign sink_imag_out = ~sink_real_out;
   // valid kept up except gaps, count on handshake
   always @(posedge clk_sys_in or posedge reset_in)
      if (reset_in)
      begin
         sink_valid_out <= 1'b0;
         source_ready_out <= 1'b0;
         sent_q <= 16'h0000;
      end
      else
      begin
         sink_valid_out <= !gap_in;
         source_ready_out <= !stall_in;
         if (sink_valid_out && sink_ready_in)
            sent_q <= sent_q + 16'h0001;
      end
endmodule // fftbf_far_model

// *** tb/burst_fft_block_flow_test.sv ***
`timescale 1ns/1ps
// ****************************************
// burst flow bench
// ****************************************
module burst_fft_block_flow_test;
   localparam N = 64;
   localparam DEPTH = 4;
   reg clk_sys_in = 1'b0;
   reg reset_in = 1'b1;
   reg gap = 1'b0;
   reg stall = 1'b0;
   wire s_valid, s_ready, s_sop, s_eop, s_inv, o_ready, o_valid, o_sop, o_eop, cfg_err;
   wire [15:0] s_re, s_im, o_re, o_im, sent;
   wire [5:0] o_exp;
   reg [39:0] got [0:4*N-1];
   integer failures = 0;
   integer checks_done = 0;
   integer idx = 0;
   integer acc_at_eop = 0;
   always #2.5 clk_sys_in = ~clk_sys_in;
   fftbf_core #(.POINTS(N)) uut
   (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .sink_valid_in(s_valid), .sink_ready_out(s_ready),
      .sink_sop_in(s_sop), .sink_eop_in(s_eop), .inverse_in(s_inv),
      .sink_real_in(s_re), .sink_imag_in(s_im), .source_ready_in(o_ready),
      .source_valid_out(o_valid), .source_sop_out(o_sop), .source_eop_out(o_eop),
      .source_real_out(o_re), .source_imag_out(o_im), .source_exp_out(o_exp),
      .cfg_error_out(cfg_err)
   );
   fftbf_far_model #(.N(N)) far
   (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .gap_in(gap), .stall_in(stall),
      .sink_ready_in(s_ready), .sink_valid_out(s_valid), .sink_sop_out(s_sop),
      .sink_eop_out(s_eop), .inverse_out(s_inv), .sink_real_out(s_re),
      .sink_imag_out(s_im), .source_ready_out(o_ready), .sent_out(sent)
   );
   // collect the first 4*N output transfers
   always @(posedge clk_sys_in)
      if (o_valid && o_ready && idx < 4*N)
      begin
         got[idx] <= {o_sop, o_eop, o_exp, o_re, o_im};
         if (o_eop && acc_at_eop == 0)
            acc_at_eop <= sent;
         idx <= idx + 1;
      end
   task check(input [39:0] seen, input [39:0] want, input string what);
      begin
         checks_done = checks_done + 1;
         if (seen !== want)
         begin
            failures = failures + 1;
            $display("FAIL %s expected %h seen %h", what, want, seen);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d failures %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // stand-in transform: copy, imag negated on inverse blocks
   function [39:0] want_of(input integer g);
      reg [15:0] k;
      reg [15:0] im;
      begin
         k = g;
         im = ~k;
         if ((g / N) % 2 == 1)
            im = -im;
         want_of = {g % N == 0, g % N == N - 1, 6'h00, k, im};
      end
   endfunction
   // wait for outputs, toggling the sink stall if asked
   task wait_out(input integer n, input reg toggle);
      integer t;
      begin
         t = 0;
         while (idx < n && t < 20000)
         begin
            @(negedge clk_sys_in);
            stall = toggle & ~stall;
            t = t + 1;
         end
         stall = 1'b0;
      end
   endtask
   task check_range(input integer a, input integer b);
      integer g;
      begin
         for (g = a; g < b; g = g + 1)
            check(got[g], want_of(g), "sample");
      end
   endtask
   // two back to back blocks, early samples of the next
   task t_plain;
      begin
         wait_out(2*N, 1'b0);
         check_range(0, 2*N);
         check(acc_at_eop > N && acc_at_eop <= N + DEPTH, 1'b1, "early");
         check(cfg_err, 1'b0, "cfg");
      end
   endtask
   // input gap mid unload, then a stalling sink
   task t_stall_gap;
      integer held;
      begin
         wait_out(2*N + 8, 1'b0);
         gap = 1'b1;
         repeat (3) @(negedge clk_sys_in);
         held = idx;
         repeat (8) @(negedge clk_sys_in);
         check(idx, held, "gap");
         gap = 1'b0;
         wait_out(4*N, 1'b1);
         check_range(2*N, 4*N);
      end
   endtask
   initial
   begin
      #200000;
      failures = failures + 1;
      test_done;
   end
   initial
   begin
      repeat (5) @(negedge clk_sys_in);
      reset_in = 1'b0;
      t_plain;
      t_stall_gap;
      test_done;
   end
endmodule // burst_fft_block_flow_test
bind fftbf_core fftbf_checker #(.POINTS(POINTS), .DATA_W(DATA_W), .TWID_W(TWID_W)) chk
(
   .clk_sys_in, .reset_in, .sink_valid_in, .sink_ready_out, .source_ready_in,
   .source_valid_out, .source_sop_out, .source_eop_out, .source_real_out,
   .source_imag_out, .source_exp_out, .cfg_error_out
);
